// File: hdl/lcdp_pkg.sv
// Constants shared by the display driver pin interface
`default_nettype none
package lcdp_pkg;
    // ------------------------------------------------------------
    // Host pin synchroniser bit positions
    // ------------------------------------------------------------
    localparam int SY_CS_N = 0;
    localparam int SY_CS = 1;
    localparam int SY_RD = 2;
    localparam int SY_WR = 3;
    localparam int SY_DC = 4;
    localparam int SY_FAM = 5;
    localparam int SY_PAR = 6;
    localparam int SY_MST = 7;
    localparam int SY_OSC = 8;
    localparam int SY_DATA = 9;
    localparam int SY_W = 17;
    localparam int SER_DATA_BIT = 7;
    localparam int SER_CLK_BIT = 6;
    localparam int BUSY_BIT = 7;
    // ------------------------------------------------------------
    // Serial shift and panel geometry
    // ------------------------------------------------------------
    localparam logic [2:0] SER_LAST = 3'h7;
    localparam int SEG_N = 224;
    localparam int COM_N = 64;
    localparam logic [6:0] LINE_LAST = 7'h40;
    // ------------------------------------------------------------
    // Panel synchroniser bit positions
    // ------------------------------------------------------------
    localparam int PS_FR = 0;
    localparam int PS_SYNC = 1;
    localparam int PS_DOF = 2;
    localparam int PS_BLANK = 3;
    localparam int PS_SAVE = 4;
    localparam int PS_REV = 5;
    localparam int PS_MST = 6;
    localparam int PS_W = 7;
    // ------------------------------------------------------------
    // Drive level codes for segment and common outputs
    // ------------------------------------------------------------
    localparam logic [2:0] LV_VDD = 3'h0;
    localparam logic [2:0] LV_BIAS1 = 3'h1;
    localparam logic [2:0] LV_BIAS2 = 3'h2;
    localparam logic [2:0] LV_BIAS3 = 3'h3;
    localparam logic [2:0] LV_BIAS4 = 3'h4;
    localparam logic [2:0] LV_BIAS5 = 3'h5;
endpackage
`default_nettype wire

// File: hdl/lcdp_pin_if.sv
// Host port and panel timing logic of the display driver
//
// What this block does
// (R1) Parallel select high parallel, low serial
// (R2) Serial: data bit 7, clock bit 6
// (R3) Transfers only when both chip selects active
// (R4) Data/command select routes display or control
// (R5) Level-sensitive low reset initialises device
// (R6) Family select high 68-style, low 80-style
// (R7) 80-style read strobe low drives bus
// (R8) 68-style enable high qualifies bus cycles
// (R9) 80-style write captured on strobe leading edge
// (R10) 68-style direction high read, low write
// (R11) Serial mode is write only
// (R12) Master drives panel timing, slave receives it
// (R13) Oscillator source select enables internal oscillator
// (R14) Display clock output only master with oscillator
// (R15) Cascade ties oscillator selects, joins clocks
// (R16) Segment level from pixel, phase, mode
// (R17) Common level from scan bit, phase
// (R18) Serial MSB first, byte on eighth clock
// (R19) Inactive chip select clears serial state
// (R20) Select and direction decode four cycle types
// (R21) Busy flag on bit 7, blocks others
// (R22) Host strobes synchronised before use
`default_nettype none
module lcdp_pin_if (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic panelClk,
    input wire logic chipSelectLow_n,
    input wire logic chipSelectHigh,
    input wire logic dataCommandSelect,
    input wire logic readStrobe,
    input wire logic writeStrobe,
    input wire logic busFamilySelect,
    input wire logic parallelSelect,
    input wire logic masterSelect,
    input wire logic oscSourceSelect,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic [7:0] dataOe,
    input wire logic busy,
    input wire logic [6:0] statusLow,
    input wire logic [7:0] readData,
    output logic readRequest,
    output logic byteValid,
    output logic [7:0] byteData,
    output logic byteIsDisplay,
    output logic oscEnable,
    output logic displayClockOut,
    output logic displayClockOe,
    input wire logic displayBlank,
    input wire logic powerSave,
    input wire logic reverseDisplay,
    input wire logic [lcdp_pkg::SEG_N-1:0] pixelData,
    input wire logic acPhaseIn,
    input wire logic frameSyncIn,
    input wire logic blankIn,
    output logic acPhaseOut,
    output logic acPhaseOe,
    output logic frameSyncOut,
    output logic frameSyncOe,
    output logic blankOut,
    output logic blankOe,
    output logic [lcdp_pkg::SEG_N*3-1:0] columnDrive,
    output logic [lcdp_pkg::COM_N*3-1:0] rowDrive
);
    // ------------------------------------------------------------
    // Level decode functions
    // ------------------------------------------------------------
    // Segment level from pixel, phase, reversal and save
    function automatic logic [2:0] segLevel(input logic pix,
        input logic fr, input logic rev, input logic save);
        logic p;
        p = pix ^ rev;
        if (save) begin
            segLevel = lcdp_pkg::LV_VDD;
        end else begin
            case ({p, fr})
                2'h3: segLevel = lcdp_pkg::LV_VDD;
                2'h2: segLevel = lcdp_pkg::LV_BIAS5;
                2'h1: segLevel = lcdp_pkg::LV_BIAS2;
                default: segLevel = lcdp_pkg::LV_BIAS3;
            endcase
        end
    endfunction

    // Common level from scan bit, phase and save
    function automatic logic [2:0] comLevel(input logic scan,
        input logic fr, input logic save);
        if (save) begin
            comLevel = lcdp_pkg::LV_VDD;
        end else begin
            case ({scan, fr})
                2'h3: comLevel = lcdp_pkg::LV_BIAS5;
                2'h2: comLevel = lcdp_pkg::LV_VDD;
                2'h1: comLevel = lcdp_pkg::LV_BIAS1;
                default: comLevel = lcdp_pkg::LV_BIAS4;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Host pin synchroniser
    // ------------------------------------------------------------
    logic [lcdp_pkg::SY_W-1:0] sy1;
    logic [lcdp_pkg::SY_W-1:0] sy2;
    logic [lcdp_pkg::SY_W-1:0] sy3;
    wire [lcdp_pkg::SY_W-1:0] pinVec = {dataIn, oscSourceSelect,
        masterSelect, parallelSelect, busFamilySelect,
        dataCommandSelect, writeStrobe, readStrobe, chipSelectHigh,
        chipSelectLow_n};

    // (R22) two stages, then a history stage for edges
    always_ff @(posedge clk) begin
        sy1 <= pinVec;
        sy2 <= sy1;
        sy3 <= sy2;
    end

    // ------------------------------------------------------------
    // Bus cycle decode
    // ------------------------------------------------------------
    wire [7:0] dSync = sy2[lcdp_pkg::SY_DATA +: 8];
    // (R3) both chip selects must be active
    wire chipActive = !sy2[lcdp_pkg::SY_CS_N] && sy2[lcdp_pkg::SY_CS];
    // (R1) parallel when select high, serial when low
    wire parMode = sy2[lcdp_pkg::SY_PAR];
    // (R6) family select high is 68-style
    wire mode68 = sy2[lcdp_pkg::SY_FAM];
    wire dcSel = sy2[lcdp_pkg::SY_DC];
    wire rdNow = sy2[lcdp_pkg::SY_RD];
    wire rdOld = sy3[lcdp_pkg::SY_RD];
    wire wrNow = sy2[lcdp_pkg::SY_WR];
    wire wrOld = sy3[lcdp_pkg::SY_WR];
    // (R8) enable high qualifies a cycle; (R10) direction pin
    wire cyc68 = mode68 && rdNow;
    wire read68 = cyc68 && wrNow;
    wire wrEdge68 = mode68 && rdOld && !rdNow && !wrNow;
    wire rdEdge68 = mode68 && rdNow && !rdOld && wrNow;
    // (R7) active low read; (R9) write leading edge
    wire read80 = !mode68 && !rdNow;
    wire wrEdge80 = !mode68 && wrOld && !wrNow;
    wire rdEdge80 = !mode68 && rdOld && !rdNow;
    wire busRead = parMode && chipActive && (read68 || read80);
    // (R21) a display read is refused while busy
    wire readAllowed = busRead && !(dcSel && busy);
    wire parWrite = parMode && chipActive && (wrEdge68 || wrEdge80);
    // (R20) display data read starts the holder fetch
    wire parDataRd = parMode && chipActive && dcSel && !busy &&
        (rdEdge68 || rdEdge80);

    // ------------------------------------------------------------
    // Serial shift register and counter
    // ------------------------------------------------------------
    logic [7:0] shiftReg;
    logic [2:0] bitCnt;
    // (R2) serial data and clock taken from bus bits 7 and 6
    wire serData = dSync[lcdp_pkg::SER_DATA_BIT];
    wire sclRise = sy2[lcdp_pkg::SY_DATA + lcdp_pkg::SER_CLK_BIT] &&
        !sy3[lcdp_pkg::SY_DATA + lcdp_pkg::SER_CLK_BIT];
    wire serStep = !parMode && chipActive && sclRise;
    wire serByte = serStep && (bitCnt == lcdp_pkg::SER_LAST);
    wire [7:0] next_shift = {shiftReg[6:0], serData};

    // (R18) MSB first; (R19) cleared while chip inactive
    always_ff @(posedge clk) begin
        if (!rst_n || !chipActive || parMode) begin
            shiftReg <= 8'h00;
            bitCnt <= 3'h0;
        end else if (serStep) begin
            shiftReg <= next_shift;
            bitCnt <= bitCnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Byte hand-off to the core
    // ------------------------------------------------------------
    wire anyByte = (parWrite || serByte) && !busy;
    wire [7:0] next_byte = parMode ? dSync : next_shift;

    // (R4) select level routes byte to display or control;
    // (R21) writes are dropped while busy
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            byteValid <= 1'b0;
            byteData <= 8'h00;
            byteIsDisplay <= 1'b0;
            readRequest <= 1'b0;
        end else begin
            byteValid <= anyByte;
            readRequest <= parDataRd;
            if (anyByte) begin
                byteData <= next_byte;
                byteIsDisplay <= dcSel;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    // (R21) status read shows busy on bit 7
    wire [7:0] statusWord = {busy, statusLow};
    wire [7:0] next_dataOut = dcSel ? readData : statusWord;

    // (R5) held at rest while reset is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dataOut <= 8'h00;
        end else begin
            dataOut <= next_dataOut;
        end
    end

    // (R3) (R11) bus driven only for allowed parallel reads
    assign dataOe = (rst_n && readAllowed) ? 8'hFF : 8'h00;

    // ------------------------------------------------------------
    // Display clock source
    // ------------------------------------------------------------
    logic oscDiv;
    wire mstClk = sy2[lcdp_pkg::SY_MST];
    wire oscClk = sy2[lcdp_pkg::SY_OSC];

    // (R13) oscillator stand-in runs only when enabled
    always_ff @(posedge clk) begin
        if (!rst_n || !oscClk) begin
            oscDiv <= 1'b0;
        end else begin
            oscDiv <= !oscDiv;
        end
    end

    assign oscEnable = oscClk;
    assign displayClockOut = oscDiv;
    // (R14) pin is an output only for master with oscillator
    assign displayClockOe = mstClk && oscClk;

    // ------------------------------------------------------------
    // Panel domain synchronisers
    // ------------------------------------------------------------
    logic rstP1;
    logic rstP2;
    logic [lcdp_pkg::PS_W-1:0] ps1;
    logic [lcdp_pkg::PS_W-1:0] ps2;
    logic syncOld;
    wire [lcdp_pkg::PS_W-1:0] panelVec = {masterSelect, reverseDisplay,
        powerSave, displayBlank, blankIn, frameSyncIn, acPhaseIn};

    // Reset level and panel inputs cross in two stages
    always_ff @(posedge panelClk) begin
        rstP1 <= rst_n;
        rstP2 <= rstP1;
        ps1 <= panelVec;
        ps2 <= ps1;
        syncOld <= ps2[lcdp_pkg::PS_SYNC];
    end

    wire panelRst = !rstP2;
    wire isMaster = ps2[lcdp_pkg::PS_MST];
    wire slaveSyncRise = ps2[lcdp_pkg::PS_SYNC] && !syncOld;

    // ------------------------------------------------------------
    // Panel timing generator
    // ------------------------------------------------------------
    logic [6:0] lineCnt;
    logic frReg;
    logic syncReg;
    wire lineWrap = (lineCnt == lcdp_pkg::LINE_LAST);
    wire [6:0] next_line = (lineWrap || (!isMaster && slaveSyncRise)) ?
        7'h00 : lineCnt + 7'h01;

    // (R12) master makes phase and alignment; slave follows
    always_ff @(posedge panelClk) begin
        if (panelRst) begin
            lineCnt <= 7'h00;
            frReg <= 1'b0;
            syncReg <= 1'b0;
        end else begin
            lineCnt <= next_line;
            syncReg <= (next_line == 7'h00);
            if (lineWrap) begin
                frReg <= !frReg;
            end
        end
    end

    wire acPhase = isMaster ? frReg : ps2[lcdp_pkg::PS_FR];
    wire blankNow = isMaster ? ps2[lcdp_pkg::PS_BLANK] :
        ps2[lcdp_pkg::PS_DOF];
    wire saveNow = ps2[lcdp_pkg::PS_SAVE] || blankNow || panelRst;

    // (R12) timing pins driven only by a master
    assign acPhaseOut = frReg;
    assign frameSyncOut = syncReg;
    assign blankOut = ps2[lcdp_pkg::PS_BLANK];
    assign acPhaseOe = isMaster;
    assign frameSyncOe = isMaster;
    assign blankOe = isMaster;

    // ------------------------------------------------------------
    // Segment and common drivers
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < lcdp_pkg::SEG_N; gi++) begin : gSeg
            // (R16) segment level select
            always_ff @(posedge panelClk) begin
                columnDrive[gi*3 +: 3] <= segLevel(pixelData[gi],
                    acPhase, ps2[lcdp_pkg::PS_REV], saveNow);
            end
        end
        for (gi = 0; gi < lcdp_pkg::COM_N; gi++) begin : gCom
            // (R17) common level select
            always_ff @(posedge panelClk) begin
                rowDrive[gi*3 +: 3] <= comLevel(lineCnt == 7'(gi),
                    acPhase, saveNow);
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_bus_hiz: assert property ( // R3
        @(posedge clk) disable iff (!rst_n)
        !chipActive |-> dataOe == 8'h00)
        else $error("bus driven while chip inactive");
    chk_serial_noread: assert property ( // R11
        @(posedge clk) disable iff (!rst_n)
        !parMode |-> dataOe == 8'h00)
        else $error("bus driven in serial mode");
    chk_serial_byte: assert property ( // R18
        @(posedge clk) disable iff (!rst_n)
        serByte && !busy |=> byteValid &&
        byteData[0] == $past(serData) && byteIsDisplay == $past(dcSel))
        else $error("serial byte not formed");
    chk_cs_clear: assert property ( // R19
        @(posedge clk) disable iff (!rst_n)
        !chipActive |=> bitCnt == 3'h0 && shiftReg == 8'h00)
        else $error("serial state kept while inactive");
    chk_status_busy: assert property ( // R21
        @(posedge clk) disable iff (!rst_n)
        busRead && !dcSel ##1 busRead && !dcSel |->
        dataOut[lcdp_pkg::BUSY_BIT] == $past(busy))
        else $error("busy flag not on bit 7");
    chk_busy_block: assert property ( // R21
        @(posedge clk) disable iff (!rst_n)
        busy |=> !byteValid)
        else $error("write taken while busy");
    chk_write_edge: assert property ( // R9
        @(posedge clk) disable iff (!rst_n)
        parMode && chipActive && wrEdge80 && !busy |=>
        byteValid && byteData == $past(dSync))
        else $error("80-style write not captured");
    chk_read_68: assert property ( // R8
        @(posedge clk) disable iff (!rst_n)
        parMode && chipActive && mode68 && rdNow && wrNow && !dcSel
        |-> dataOe == 8'hFF)
        else $error("68-style status read not driven");
    chk_clock_pin: assert property ( // R14
        @(posedge clk) disable iff (!rst_n)
        displayClockOe |-> oscEnable && mstClk)
        else $error("display clock driven wrongly");
    chk_save_level: assert property ( // R16
        @(posedge panelClk) disable iff (panelRst)
        ps2[lcdp_pkg::PS_SAVE] |=> columnDrive == '0 && rowDrive == '0)
        else $error("power save not at top supply");
    chk_frame_flip: assert property ( // R12
        @(posedge panelClk) disable iff (panelRst)
        lineWrap |=> frReg != $past(frReg) && lineCnt == 7'h00)
        else $error("phase not toggled at frame end");
    chk_reset_quiet: assert property ( // R5
        @(posedge clk) !rst_n |=> !byteValid && !readRequest)
        else $error("activity during reset");

    cov_serial_byte: cover property (@(posedge clk) serByte);
    cov_par_write: cover property (@(posedge clk) parWrite && !busy);
    cov_status_read: cover property (@(posedge clk)
        busRead && !dcSel && busy);
    cov_frame_wrap: cover property (@(posedge panelClk) lineWrap);
endmodule
`default_nettype wire

// File: verif/lcdp_host_model.sv
// Host bus and serial master model facing the display driver port
`default_nettype none
module lcdp_host_model (
    input wire logic clk,
    input wire logic [7:0] dataOut,
    input wire logic [7:0] dataOe,
    output var logic chipSelectLow_n,
    output var logic chipSelectHigh,
    output var logic dataCommandSelect,
    output var logic readStrobe,
    output var logic writeStrobe,
    output wire logic [7:0] dataIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] hostData = 8'h00;
    logic hostOe = 1'b0;
    // -----------------------------------------------------------
    // Bus wire level
    // -----------------------------------------------------------
    // Device, host, or a released bus showing the inverse pattern
    assign dataIn = (dataOe & dataOut)
        | (~dataOe & (hostOe ? hostData : ~hostData));
    // Idle pins at time zero
    initial begin
        chipSelectLow_n = 1'b1;
        chipSelectHigh = 1'b0;
        dataCommandSelect = 1'b0;
        readStrobe = 1'b1;
        writeStrobe = 1'b1;
    end
    task automatic waitCyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Deselect first, release the bus afterwards
    task automatic deselect;
        chipSelectLow_n = 1'b1;
        chipSelectHigh = 1'b0;
        waitCyc(3);
        hostOe = 1'b0;
        waitCyc(3);
    endtask
    // -----------------------------------------------------------
    // Transfers
    // -----------------------------------------------------------
    // host marks the transfer kind
    task automatic busCycle(input logic fam, input logic rd,
        input logic dc, input logic [7:0] d, input logic sel,
        output logic [7:0] oe, output logic [7:0] q);
        @(negedge clk);
        // Strobes settle before select, so no false enable edge
        readStrobe = ~fam;
        writeStrobe = fam ? rd : 1'b1;
        hostData = d;
        hostOe = ~rd;
        waitCyc(4);
        chipSelectLow_n = ~sel;
        chipSelectHigh = sel;
        dataCommandSelect = dc;
        waitCyc(4);
        if (fam) readStrobe = 1'b1;
        else if (rd) readStrobe = 1'b0;
        else writeStrobe = 1'b0;
        waitCyc(5);
        oe = dataOe;
        q = dataOut;
        readStrobe = ~fam;
        writeStrobe = fam ? rd : 1'b1;
        waitCyc(5);
        deselect();
    endtask
    // MSB first, serial clock idles low
    task automatic serialSend(input logic dc, input logic [7:0] d,
        input int n);
        @(negedge clk);
        chipSelectLow_n = 1'b0;
        chipSelectHigh = 1'b1;
        dataCommandSelect = dc;
        hostData = 8'h00;
        hostOe = 1'b1;
        for (int i = 7; i > 7 - n; i--) begin
            hostData[7] = d[i];
            waitCyc(4);
            hostData[6] = 1'b1;
            waitCyc(4);
            hostData[6] = 1'b0;
        end
        waitCyc(4);
        deselect();
    endtask
endmodule
`default_nettype wire

// File: verif/test_lcd_driver_pin_interface.sv
// Self-checking bench for the display driver pin interface
`default_nettype none
module test_lcd_driver_pin_interface;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] mode;
        logic dc;
        logic [7:0] data;
        logic pix;
        logic fr;
        logic rev;
        logic [2:0] lvl;
    } lcdp_row_t;
    localparam lcdp_row_t ROWS[8] = '{
        '{2'h0, 1'b1, 8'hA5, 1'b1, 1'b1, 1'b0, lcdp_pkg::LV_VDD},
        '{2'h0, 1'b0, 8'h5A, 1'b1, 1'b0, 1'b0, lcdp_pkg::LV_BIAS5},
        '{2'h1, 1'b1, 8'h3C, 1'b0, 1'b1, 1'b0, lcdp_pkg::LV_BIAS2},
        '{2'h1, 1'b0, 8'hC3, 1'b0, 1'b0, 1'b0, lcdp_pkg::LV_BIAS3},
        '{2'h2, 1'b1, 8'h81, 1'b1, 1'b1, 1'b1, lcdp_pkg::LV_BIAS2},
        '{2'h2, 1'b0, 8'h7E, 1'b1, 1'b0, 1'b1, lcdp_pkg::LV_BIAS3},
        '{2'h0, 1'b1, 8'h00, 1'b0, 1'b1, 1'b1, lcdp_pkg::LV_VDD},
        '{2'h1, 1'b0, 8'hFF, 1'b0, 1'b0, 1'b1, lcdp_pkg::LV_BIAS5}};
    logic clk = 1'b0;
    logic panelClk = 1'b0;
    logic rst_n = 1'b0;
    logic parallelSelect = 1'b1;
    logic busFamilySelect = 1'b0;
    logic masterSelect = 1'b0;
    logic oscSourceSelect = 1'b1;
    logic busy = 1'b0;
    logic [6:0] statusLow = 7'h2B;
    logic [7:0] readData = 8'hC6;
    logic displayBlank = 1'b0;
    logic powerSave = 1'b0;
    logic reverseDisplay = 1'b0;
    logic [lcdp_pkg::SEG_N-1:0] pixelData = '0;
    logic acPhaseIn = 1'b0;
    logic frameSyncIn = 1'b0;
    logic blankIn = 1'b0;
    wire logic acPhaseOut, frameSyncOut, blankOut, blankOe;
    wire logic chipSelectLow_n, chipSelectHigh, dataCommandSelect;
    wire logic readStrobe, writeStrobe, readRequest, byteValid;
    wire logic byteIsDisplay, oscEnable, displayClockOut;
    wire logic displayClockOe, acPhaseOe, frameSyncOe;
    wire logic [7:0] dataIn, dataOut, dataOe, byteData;
    wire logic [lcdp_pkg::SEG_N*3-1:0] columnDrive;
    wire logic [lcdp_pkg::COM_N*3-1:0] rowDrive;
    int error_cnt = 0;
    int samples_checked = 0;
    int reqCnt = 0;
    int okRows;
    logic [8:0] gotBytes[$];
    logic [7:0] oe, q;
    logic prevClk;
    lcdp_row_t r;
    // -----------------------------------------------------------
    // Clocks, instances and capture
    // -----------------------------------------------------------
    always #50 clk = ~clk;
    // Panel clock with its own phase
    initial begin
        #13;
        forever #80 panelClk = ~panelClk;
    end
    lcdp_pin_if lcdp_pin_if_inst (.*);
    lcdp_host_model lcdp_host_model_inst (.*);
    // Collect written bytes and read requests
    always @(posedge clk) begin
        if (byteValid === 1'b1) gotBytes.push_back({byteIsDisplay, byteData});
        if (readRequest === 1'b1) reqCnt++;
    end
    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task automatic checkVal(input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic checkFlag(input logic exp, input logic got);
        checkVal(16'(exp), 16'(got));
    endtask
    task automatic wclk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic expectBytes(input int n, input logic [8:0] v);
        checkVal(16'(n), 16'(gotBytes.size()));
        if (n > 0 && gotBytes.size() > 0) checkVal(16'(v), 16'(gotBytes[0]));
        gotBytes.delete();
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        #1000000;
        error_cnt++;
        report_and_stop();
    end
    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        wclk(11);
        checkFlag(1'b0, byteValid); // no byte in reset
        checkVal(16'h0000, 16'(dataOe)); // bus released in reset
        checkFlag(1'b1, rowDrive === '0); // rows at top supply
        wclk(1);
        rst_n = 1'b1;
        wclk(4);
        $display("Test reset done");
        for (int i = 0; i < 8; i++) begin
            r = ROWS[i];
            parallelSelect = (r.mode != 2'h2);
            busFamilySelect = (r.mode == 2'h1);
            pixelData = {lcdp_pkg::SEG_N{r.pix}};
            acPhaseIn = r.fr;
            reverseDisplay = r.rev;
            wclk(6);
            if (r.mode == 2'h2) lcdp_host_model_inst.serialSend(r.dc, r.data, 8);
            else lcdp_host_model_inst.busCycle(r.mode[0], 1'b0, r.dc,
                r.data, 1'b1, oe, q);
            expectBytes(1, {r.dc, r.data}); // byte
            checkVal(16'(r.lvl), 16'(columnDrive[2:0])); // first column
            checkVal(16'(r.lvl), 16'(columnDrive[671:669])); // last one
        end
        $display("Test table done");
        parallelSelect = 1'b1;
        busFamilySelect = 1'b0;
        wclk(5);
        lcdp_host_model_inst.busCycle(0, 0, 1, 8'h11, 0, oe, q);
        expectBytes(0, 9'h000); // write ignored
        lcdp_host_model_inst.busCycle(0, 1, 0, 8'hFF, 0, oe, q);
        checkVal(16'h0000, 16'(oe)); // bus stays released
        busy = 1'b1;
        lcdp_host_model_inst.busCycle(0, 1, 0, 8'hFF, 1, oe, q);
        checkVal(16'h00FF, 16'(oe)); // status drives bus
        checkVal(16'h00AB, 16'(q)); // busy on top bit
        lcdp_host_model_inst.busCycle(0, 1, 1, 8'hFF, 1, oe, q);
        checkVal(16'h0000, 16'(oe)); // data read refused
        lcdp_host_model_inst.busCycle(0, 0, 0, 8'h22, 1, oe, q);
        expectBytes(0, 9'h000); // write refused
        checkVal(16'h0000, 16'(reqCnt)); // no read request
        busy = 1'b0;
        lcdp_host_model_inst.busCycle(0, 1, 1, 8'hFF, 1, oe, q);
        checkVal(16'h00C6, 16'(q)); // display data read
        checkVal(16'h0001, 16'(reqCnt)); // one read request
        busFamilySelect = 1'b1;
        wclk(5);
        lcdp_host_model_inst.busCycle(1, 1, 0, 8'hFF, 1, oe, q);
        checkVal(16'h002B, 16'(q)); // enable status read
        $display("Test bus done");
        parallelSelect = 1'b0;
        wclk(5);
        lcdp_host_model_inst.serialSend(1, 8'hF0, 3);
        lcdp_host_model_inst.serialSend(0, 8'h96, 8);
        expectBytes(1, 9'h096); // partial byte dropped
        lcdp_host_model_inst.busCycle(0, 1, 0, 8'hFF, 1, oe, q);
        checkVal(16'h0000, 16'(oe)); // serial has no read
        $display("Test serial done");
        for (int k = 0; k < 4; k++) begin
            masterSelect = (k < 2);
            oscSourceSelect = ~k[0];
            wclk(6);
            prevClk = displayClockOut;
            wclk(1);
            checkFlag(masterSelect & oscSourceSelect, displayClockOe);
            checkFlag(oscSourceSelect, oscEnable); // oscillator on
            checkFlag(oscSourceSelect & ~prevClk, displayClockOut);
            checkFlag(masterSelect, acPhaseOe); // phase driven
            checkFlag(masterSelect, frameSyncOe); // sync driven
            checkFlag(masterSelect, blankOe); // blank driven
        end
        $display("Test clocking done");
        masterSelect = 1'b0;
        oscSourceSelect = 1'b1;
        for (int k = 0; k < 2; k++) begin
            // Own blanking only counts for a master
            masterSelect = (k == 0);
            displayBlank = (k == 0);
            powerSave = (k == 1);
            wclk(20);
            checkFlag(1'b1, columnDrive === '0); // forced top supply
            checkFlag(1'b1, rowDrive === '0); // forced top supply
        end
        powerSave = 1'b0;
        masterSelect = 1'b0;
        acPhaseIn = 1'b1;
        wclk(20);
        okRows = 0;
        for (int j = 0; j < lcdp_pkg::COM_N; j++) begin
            if (rowDrive[3*j+:3] inside {lcdp_pkg::LV_BIAS5,
                lcdp_pkg::LV_BIAS1}) okRows++;
        end
        checkVal(16'(lcdp_pkg::COM_N), 16'(okRows)); // row levels
        $display("Test panel done");
        report_and_stop();
    end
endmodule
`default_nettype wire
